// >>> include/pscs_pkg.sv
// package for the scan-cycle sequencer: phases, widths and reset values
// assumes a single clock domain and no register bus
package pscs_pkg;
    typedef enum logic [3:0] {
        PH_RESET,
        PH_INIT_CLEAR,
        PH_INIT_CHECK,
        PH_DIAG,
        PH_OUT_REFRESH,
        PH_PROGRAM,
        PH_INTERRUPT,
        PH_IN_REFRESH,
        PH_END,
        PH_COMM,
        PH_FAULT
    } pscs_phase_t;
    localparam int TASK_COUNT = 4;
    localparam int IRQ_SOURCES = 3;
    localparam int IRQ_PERIODIC = 0;
    localparam int IRQ_TIMER = 1;
    localparam int IRQ_CONDITION = 2;
    localparam int PC_WIDTH = 16;
    localparam int IO_WIDTH = 8;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] IO_RESET = 8'h00;
endpackage

// >>> src/pscs_sequencer.sv
// scan-cycle sequencer: init, diagnosis, I/O refresh, program, interrupt,
// end, communication service; RUN/STOP mode handling
// assumes inputs synchronous to i_clk, program engine handshakes by pulses
`timescale 1ns/1ps
module pscs_sequencer #(
    parameter int TASKS = pscs_pkg::TASK_COUNT,
    parameter int IOW = pscs_pkg::IO_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_run_request,
    input wire logic i_clear_on_run,
    input wire logic i_hold_outputs,
    input wire logic i_program_ok,
    input wire logic i_params_ok,
    input wire logic i_card_ok,
    input wire logic i_bus_ok,
    input wire logic i_sysparam_ok,
    input wire logic i_instr_done,
    input wire logic [pscs_pkg::PC_WIDTH-1:0] i_next_pc,
    input wire logic [7:0] i_next_state,
    input wire logic i_program_end,
    input wire logic i_irq_end,
    input wire logic [pscs_pkg::IRQ_SOURCES-1:0] i_irq,
    input wire logic [TASKS-1:0] i_task_active,
    input wire logic [TASKS-1:0] i_task_enable_instr,
    input wire logic [TASKS-1:0] i_task_disable_instr,
    input wire logic [IOW-1:0] i_digital_in,
    input wire logic [IOW-1:0] i_analog_in,
    input wire logic [IOW-1:0] i_prog_digital_out,
    input wire logic [IOW-1:0] i_prog_analog_out,
    input wire logic i_comm_req,
    input wire logic i_cfg_init_req,
    input wire logic i_download_req,
    input wire logic i_check_req,
    input wire logic i_force_req,
    input wire logic [3:0] i_force_bit,
    input wire logic i_force_value,
    output logic o_run_mode,
    output logic [3:0] o_phase,
    output logic o_clear_nonlatched,
    output logic o_diag_fault,
    output logic o_program_run,
    output logic o_irq_run,
    output logic [pscs_pkg::IRQ_SOURCES-1:0] o_irq_pending,
    output logic [pscs_pkg::PC_WIDTH-1:0] o_resume_pc,
    output logic [7:0] o_resume_state,
    output logic o_resume,
    output logic [TASKS-1:0] o_task_run,
    output logic [TASKS-1:0] o_task_halted,
    output logic [IOW-1:0] o_digital_out,
    output logic [IOW-1:0] o_analog_out,
    output logic [IOW-1:0] o_digital_in_img,
    output logic [IOW-1:0] o_analog_in_img,
    output logic o_comm_apply,
    output logic o_cfg_accept,
    output logic o_cfg_refused,
    output logic [IOW-1:0] o_force_mask
);

////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        pscs_pkg::pscs_phase_t phase;
        logic run_mode;
        logic clear_nonlatched;
        logic diag_fault;
        logic program_run;
        logic irq_run;
        logic [pscs_pkg::IRQ_SOURCES-1:0] irq_pending;
        logic [pscs_pkg::PC_WIDTH-1:0] resume_pc;
        logic [7:0] resume_state;
        logic resume;
        logic [TASKS-1:0] task_run;
        logic [TASKS-1:0] task_halted;
        logic [TASKS-1:0] task_on;
        logic [IOW-1:0] dig_out;
        logic [IOW-1:0] ana_out;
        logic [IOW-1:0] dig_in;
        logic [IOW-1:0] ana_in;
        logic comm_pending;
        logic comm_apply;
        logic cfg_accept;
        logic cfg_refused;
        logic [IOW-1:0] force_mask;
    } pscs_state_t;

    pscs_state_t st;
    pscs_state_t next_st;
    // synchroniser kept apart: it alone sees the raw reset
    logic [1:0] rst_sync;
    logic rst_sync_n;

    localparam pscs_state_t ST_RESET = '{
        phase: pscs_pkg::PH_RESET,
        resume_pc: pscs_pkg::PC_RESET,
        default: '0
    };

    function automatic logic [IOW-1:0] apply_force(
        input logic [IOW-1:0] value,
        input logic [IOW-1:0] mask,
        input logic [IOW-1:0] level
    );
        apply_force = (value & ~mask) | (level & mask);
    endfunction

    // forcing stores the forced level in the mask bit position of the image
    logic [IOW-1:0] force_sel;
    assign force_sel = IOW'(1) << i_force_bit;

////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.clear_nonlatched = 1'b0;
        next_st.comm_apply = 1'b0;
        next_st.cfg_accept = 1'b0;
        next_st.cfg_refused = 1'b0;
        next_st.resume = 1'b0;
        // requests arrive anytime; held until the communication step
        if (i_comm_req) begin
            next_st.comm_pending = 1'b1;
        end
        // latch interrupt events; three separate sources
        next_st.irq_pending = st.irq_pending | i_irq;
        // configuration access depends on current mode
        if (i_cfg_init_req || i_download_req || i_check_req
                || i_force_req) begin
            if (st.run_mode) begin
                next_st.cfg_refused = 1'b1;
            end else begin
                next_st.cfg_accept = 1'b1;
                if (i_force_req) begin
                    next_st.force_mask = st.force_mask | force_sel;
                    next_st.dig_out = i_force_value ?
                        (st.dig_out | force_sel) : (st.dig_out & ~force_sel);
                end
            end
        end
        unique case (st.phase)
            pscs_pkg::PH_RESET: begin
                next_st.phase = pscs_pkg::PH_INIT_CLEAR;
            end
            pscs_pkg::PH_INIT_CLEAR: begin
                next_st.clear_nonlatched = 1'b1;
                next_st.phase = pscs_pkg::PH_INIT_CHECK;
            end
            pscs_pkg::PH_INIT_CHECK: begin
                if (i_program_ok && i_params_ok) begin
                    next_st.phase = pscs_pkg::PH_DIAG;
                end else begin
                    next_st.phase = pscs_pkg::PH_FAULT;
                end
            end
            pscs_pkg::PH_DIAG: begin
                // mode is sampled here only, at the scan boundary
                if (i_run_request && !st.run_mode) begin
                    next_st.run_mode = 1'b1;
                    next_st.clear_nonlatched = i_clear_on_run;
                    next_st.task_halted = '1;
                end else if (!i_run_request && st.run_mode) begin
                    next_st.run_mode = 1'b0;
                end
                if (i_card_ok && i_bus_ok && i_sysparam_ok) begin
                    next_st.diag_fault = 1'b0;
                    next_st.phase = pscs_pkg::PH_OUT_REFRESH;
                end else begin
                    next_st.diag_fault = 1'b1;
                    // a fault stops the CPU at this boundary, not inside a scan
                    next_st.run_mode = 1'b0;
                    next_st.phase = pscs_pkg::PH_FAULT;
                end
            end
            pscs_pkg::PH_OUT_REFRESH: begin
                // program results of the previous scan leave here
                if (st.run_mode) begin
                    next_st.dig_out = i_prog_digital_out;
                    next_st.ana_out = i_prog_analog_out;
                    next_st.force_mask = '0;
                end else if (!i_hold_outputs) begin
                    next_st.dig_out = apply_force(IOW'(0), st.force_mask,
                        st.dig_out);
                    next_st.ana_out = '0;
                end
                next_st.phase = pscs_pkg::PH_IN_REFRESH;
            end
            pscs_pkg::PH_IN_REFRESH: begin
                next_st.dig_in = i_digital_in;
                next_st.ana_in = i_analog_in;
                if (st.run_mode) begin
                    for (int t = 0; t < TASKS; t++) begin
                        if (i_task_disable_instr[t]) begin
                            next_st.task_on[t] = 1'b0;
                        end else begin
                            next_st.task_on[t] = i_task_active[t]
                                || i_task_enable_instr[t];
                        end
                    end
                    next_st.program_run = 1'b1;
                    next_st.phase = pscs_pkg::PH_PROGRAM;
                end else begin
                    next_st.task_on = '0;
                    next_st.phase = pscs_pkg::PH_END;
                end
            end
            pscs_pkg::PH_PROGRAM: begin
                next_st.task_run = st.task_on;
                next_st.task_halted = st.task_halted & ~st.task_on;
                // interrupts wait for the current instruction to finish
                if (st.irq_pending != '0 && i_instr_done) begin
                    next_st.resume_pc = i_next_pc;
                    next_st.resume_state = i_next_state;
                    next_st.irq_run = 1'b1;
                    next_st.program_run = 1'b0;
                    next_st.irq_pending = i_irq;
                    next_st.phase = pscs_pkg::PH_INTERRUPT;
                end else if (i_program_end) begin
                    next_st.program_run = 1'b0;
                    next_st.task_run = '0;
                    next_st.phase = pscs_pkg::PH_END;
                end
            end
            pscs_pkg::PH_INTERRUPT: begin
                if (i_irq_end) begin
                    next_st.irq_run = 1'b0;
                    next_st.resume = 1'b1;
                    next_st.program_run = 1'b1;
                    next_st.phase = pscs_pkg::PH_PROGRAM;
                end
            end
            pscs_pkg::PH_END: begin
                next_st.phase = pscs_pkg::PH_COMM;
            end
            pscs_pkg::PH_COMM: begin
                if (st.comm_pending) begin
                    next_st.comm_apply = 1'b1;
                    next_st.comm_pending = i_comm_req;
                end
                next_st.phase = pscs_pkg::PH_DIAG;
            end
            pscs_pkg::PH_FAULT: begin
                // stays faulted; outputs off, tasks stopped
                next_st.run_mode = 1'b0;
                next_st.program_run = 1'b0;
                next_st.task_run = '0;
                next_st.dig_out = '0;
                next_st.ana_out = '0;
            end
            default: begin
                next_st.phase = pscs_pkg::PH_FAULT;
            end
        endcase
        if (!st.run_mode) begin
            next_st.task_run = '0;
            next_st.irq_run = 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // two-stage release; only the second stage gates the rest
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_sync[1];

    always_ff @(posedge i_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

////////////////////////////////////////////////////////////////////////////
    assign o_run_mode = st.run_mode;
    assign o_phase = st.phase;
    assign o_clear_nonlatched = st.clear_nonlatched;
    assign o_diag_fault = st.diag_fault;
    assign o_program_run = st.program_run;
    assign o_irq_run = st.irq_run;
    assign o_irq_pending = st.irq_pending;
    assign o_resume_pc = st.resume_pc;
    assign o_resume_state = st.resume_state;
    assign o_resume = st.resume;
    assign o_task_run = st.task_run;
    assign o_task_halted = st.task_halted;
    assign o_digital_out = st.dig_out;
    assign o_analog_out = st.ana_out;
    assign o_digital_in_img = st.dig_in;
    assign o_analog_in_img = st.ana_in;
    assign o_comm_apply = st.comm_apply;
    assign o_cfg_accept = st.cfg_accept;
    assign o_cfg_refused = st.cfg_refused;
    assign o_force_mask = st.force_mask;
endmodule

// >>> testbench/pscs_sequencer_asserts.sv
// checker for the scan sequencer: phase order, mode effects, interrupts
// assumes it is bound onto pscs_sequencer and sees only its ports
`timescale 1ns/1ps
module pscs_sequencer_asserts #(
    parameter int TASKS = 4,
    parameter int IOW = 8
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_hold_outputs,
    input wire logic [pscs_pkg::PC_WIDTH-1:0] i_next_pc,
    input wire logic [IOW-1:0] i_prog_digital_out,
    input wire logic o_run_mode,
    input wire logic [3:0] o_phase,
    input wire logic o_clear_nonlatched,
    input wire logic o_program_run,
    input wire logic o_irq_run,
    input wire logic [pscs_pkg::PC_WIDTH-1:0] o_resume_pc,
    input wire logic o_resume,
    input wire logic [TASKS-1:0] o_task_run,
    input wire logic [IOW-1:0] o_digital_out,
    input wire logic [IOW-1:0] o_analog_out,
    input wire logic o_comm_apply,
    input wire logic o_cfg_accept,
    input wire logic o_cfg_refused
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire is_diag = o_phase == pscs_pkg::PH_DIAG;
    wire is_out = o_phase == pscs_pkg::PH_OUT_REFRESH;
    wire is_in = o_phase == pscs_pkg::PH_IN_REFRESH;
    wire is_prog = o_phase == pscs_pkg::PH_PROGRAM;
    wire is_end = o_phase == pscs_pkg::PH_END;
    wire is_comm = o_phase == pscs_pkg::PH_COMM;
    ////////////////////////////////////////////////////////////////////////
    sequence s_init_start;
        o_phase == pscs_pkg::PH_RESET ##1 o_phase == pscs_pkg::PH_INIT_CLEAR;
    endsequence
    sequence s_out_entry;
        !is_out ##1 is_out;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_init_clear: assert property (
        s_init_start |-> ##[1:2] o_clear_nonlatched)
        else $error("no clear pulse after power-up");
    a_diag_first: assert property (s_out_entry |-> $past(is_diag))
        else $error("output refresh not preceded by diagnosis");
    a_input_first: assert property (
        (is_prog && $past(!is_prog)
        && $past(o_phase) != pscs_pkg::PH_INTERRUPT) |-> $past(is_in))
        else $error("program entered without input refresh");
    a_end_order: assert property (
        (is_end && $past(!is_end)) |-> $past(is_prog) || $past(is_in))
        else $error("scan end reached out of order");
    a_comm_after: assert property (
        (is_comm && $past(!is_comm)) |-> $past(is_end))
        else $error("communication step not after scan end");
    a_apply_late: assert property (
        o_comm_apply |-> is_comm || $past(is_comm))
        else $error("communication applied outside its step");
    a_stop_idle: assert property (
        (!o_run_mode && $past(!o_run_mode))
        |-> !o_program_run && !o_irq_run && o_task_run == '0)
        else $error("execution while stopped");
    a_cfg_refuse: assert property (o_cfg_refused |-> $past(o_run_mode))
        else $error("configuration refused while stopped");
    a_cfg_accept: assert property (o_cfg_accept |-> !$past(o_run_mode))
        else $error("configuration accepted while running");
    a_irq_save: assert property (
        $rose(o_irq_run) |-> o_resume_pc == $past(i_next_pc))
        else $error("next position not saved at interrupt entry");
    a_resume_src: assert property (
        o_resume |-> $past(o_phase) == pscs_pkg::PH_INTERRUPT)
        else $error("resume without interrupt routine");
    a_mode_edge: assert property (
        $changed(o_run_mode) |-> is_diag || $past(is_diag))
        else $error("mode changed inside a scan");
    a_run_out: assert property (
        (o_run_mode && is_in && $past(is_out))
        |-> o_digital_out == $past(i_prog_digital_out))
        else $error("run outputs differ from program image");
    a_stop_analog: assert property (
        (!o_run_mode && $past(!o_run_mode) && is_in
        && $past(!i_hold_outputs)) |-> o_analog_out == '0)
        else $error("analog output live while stopped");
endmodule
bind pscs_sequencer pscs_sequencer_asserts #(.TASKS(TASKS), .IOW(IOW))
    pscs_sequencer_asserts_i (.*);

// >>> testbench/pscs_io_model.sv
// model of the I/O modules: field inputs that change once per scan
// assumes the sequencer phase encoding of pscs_pkg
`timescale 1ns/1ps
module pscs_io_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_phase,
    output logic [7:0] o_digital_in,
    output logic [7:0] o_analog_in
);
    // steady through input refresh so the sampled value is known
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_digital_in <= 8'h11;
            o_analog_in <= 8'hE0;
        end else if (i_phase == pscs_pkg::PH_OUT_REFRESH) begin
            o_digital_in <= o_digital_in + 8'h13;
            o_analog_in <= o_analog_in - 8'h07;
        end
    end
endmodule

// >>> testbench/plc_scan_cycle_sequencer_test.sv
// self-checking bench for the scan sequencer: modes, order, interrupts
// assumes the checker is bound and the I/O model supplies field inputs
`timescale 1ns/1ps
module plc_scan_cycle_sequencer_test;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_run_request, i_clear_on_run, i_hold_outputs, i_program_ok;
    logic i_params_ok, i_card_ok, i_bus_ok, i_sysparam_ok, i_instr_done;
    logic i_program_end, i_irq_end, i_comm_req, i_cfg_init_req;
    logic i_download_req, i_check_req, i_force_req, i_force_value;
    logic [15:0] i_next_pc, o_resume_pc;
    logic [7:0] i_next_state, i_digital_in, i_analog_in, o_resume_state;
    logic [7:0] i_prog_digital_out, i_prog_analog_out, o_force_mask;
    logic [7:0] o_digital_out, o_analog_out, o_digital_in_img, o_analog_in_img;
    logic [2:0] i_irq, o_irq_pending;
    logic [3:0] i_task_active, i_task_enable_instr, i_task_disable_instr;
    logic [3:0] i_force_bit, o_phase, o_task_run, o_task_halted;
    logic o_run_mode, o_clear_nonlatched, o_diag_fault, o_program_run;
    logic o_irq_run, o_resume, o_comm_apply, o_cfg_accept, o_cfg_refused;
    int err_count = 0;
    int checks = 0;
    int n_clr = 0, n_acc = 0, n_ref = 0, n_res = 0, n_app = 0;
    pscs_sequencer pscs_sequencer_i (.*);
    pscs_io_model pscs_io_model_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_phase(o_phase), .o_digital_in(i_digital_in),
        .o_analog_in(i_analog_in));
    always #50 i_clk = ~i_clk;
    // pulses are counted so their exact cycle need not be guessed
    always @(posedge i_clk) begin
        n_clr += int'(o_clear_nonlatched === 1'b1);
        n_acc += int'(o_cfg_accept === 1'b1);
        n_ref += int'(o_cfg_refused === 1'b1);
        n_res += int'(o_resume === 1'b1);
        n_app += int'(o_comm_apply === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic check_cnt(input int got, input int exp);
        check_val(16'(got), 16'(exp));
    endtask
    task automatic wait_phase(input logic [3:0] p);
        int k;
        k = 0;
        while (o_phase !== p && k < 60) begin
            tick();
            k++;
        end
        if (k == 60) begin
            err_count++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {i_run_request, i_clear_on_run, i_hold_outputs, i_instr_done,
            i_program_end, i_irq_end, i_comm_req, i_cfg_init_req,
            i_download_req, i_check_req, i_force_req, i_force_value} = '0;
        {i_program_ok, i_params_ok, i_card_ok, i_bus_ok, i_sysparam_ok} = '1;
        {i_next_pc, i_next_state, i_irq, i_task_active, i_task_enable_instr,
            i_task_disable_instr, i_force_bit} = '0;
        i_prog_digital_out = 8'hA5;
        i_prog_analog_out = 8'h3C;
        tick(8);
        i_rstn = 1'b1;
        wait_phase(pscs_pkg::PH_DIAG);
        check_cnt(n_clr, 1);
        check_val(o_run_mode, 1'b0);
        i_force_bit = 4'h2;
        i_force_value = 1'b1;
        pulse(i_cfg_init_req);
        pulse(i_download_req);
        pulse(i_check_req);
        pulse(i_force_req);
        tick(2);
        check_cnt(n_acc, 4);
        check_val(o_force_mask, 8'h04);
        wait_phase(pscs_pkg::PH_IN_REFRESH);
        tick();
        check_val(o_phase, pscs_pkg::PH_END);
        check_val(o_digital_out, 8'h04);
        check_val(o_analog_out, 8'h00);
        check_val(o_digital_in_img, i_digital_in);
        i_run_request = 1'b1;
        i_clear_on_run = 1'b1;
        i_task_active = 4'b0001;
        i_task_enable_instr = 4'b0100;
        i_task_disable_instr = 4'b0010;
        wait_phase(pscs_pkg::PH_PROGRAM);
        check_val(o_run_mode, 1'b1);
        check_cnt(n_clr, 2);
        check_val(o_digital_out, 8'hA5);
        check_val(o_analog_out, 8'h3C);
        check_val(o_digital_in_img, i_digital_in);
        check_val(o_analog_in_img, i_analog_in);
        // task flags load one edge into the program phase
        tick();
        check_val(o_program_run, 1'b1);
        check_val(o_task_run, 4'b0101);
        check_val(o_task_halted, 4'b1010);
        pulse(i_cfg_init_req);
        tick();
        check_cnt(n_ref, 1);
        check_cnt(n_acc, 4);
        pulse(i_comm_req);
        tick(3);
        check_cnt(n_app, 0);
        for (int s = 0; s < 3; s++) begin
            i_next_pc = 16'h1230 + 16'(s);
            i_next_state = 8'hA0 + 8'(s);
            i_irq[s] = 1'b1;
            tick();
            i_irq = '0;
            tick(2);
            check_val(o_irq_run, 1'b0);
            check_val(o_irq_pending, 16'(1) << s);
            i_instr_done = 1'b1;
            wait_phase(pscs_pkg::PH_INTERRUPT);
            i_instr_done = 1'b0;
            check_val(o_resume_pc, 16'h1230 + 16'(s));
            check_val(o_resume_state, 8'hA0 + 8'(s));
            check_val(o_irq_pending, 16'h0000);
            pulse(i_irq_end);
            wait_phase(pscs_pkg::PH_PROGRAM);
            tick();
            check_cnt(n_res, s + 1);
        end
        i_run_request = 1'b0;
        i_hold_outputs = 1'b1;
        i_prog_digital_out = 8'h5A;
        pulse(i_program_end);
        wait_phase(pscs_pkg::PH_DIAG);
        // the apply pulse is counted at the edge after it appears
        tick();
        check_cnt(n_app, 1);
        wait_phase(pscs_pkg::PH_END);
        check_val(o_run_mode, 1'b0);
        check_val(o_digital_out, 8'hA5);
        check_val(o_analog_out, 8'h3C);
        check_cnt(n_clr, 2);
        i_clear_on_run = 1'b0;
        i_hold_outputs = 1'b0;
        i_run_request = 1'b1;
        wait_phase(pscs_pkg::PH_PROGRAM);
        check_cnt(n_clr, 2);
        check_val(o_digital_out, 8'h5A);
        i_bus_ok = 1'b0;
        pulse(i_program_end);
        wait_phase(pscs_pkg::PH_FAULT);
        check_val(o_diag_fault, 1'b1);
        finish_test();
    end
endmodule
